// ==== logic/timer_two_params.svh ====
`ifndef TIMER_TWO_PARAMS_SVH
`define TIMER_TWO_PARAMS_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define CTRL_ADDR 8'hc8
`define MODE_ADDR 8'hc9
`define RCAP_LO_ADDR 8'hca
`define RCAP_HI_ADDR 8'hcb
`define CNT_LO_ADDR 8'hcc
`define CNT_HI_ADDR 8'hcd
`define PRESCALE_ADDR 8'hce

// ************************************************************
// reset values
// ************************************************************
`define CTRL_RESET 8'h00
`define MODE_RESET 2'h0
`define PRESCALE_RESET 4'h0
`define WORD_RESET 16'h0000

// ************************************************************
// field positions in the mode register
// ************************************************************
`define MODE_DOWN_BIT 0
`define MODE_TOGGLE_BIT 1

// ************************************************************
// count limits
// ************************************************************
`define COUNT_MIN 16'h0000
`define COUNT_MAX 16'hffff

`endif

// ==== logic/timer_two_pkg.sv ====
package timer_two_pkg;

  // ************************************************************
  // control register layout, bit 7 down to bit 0
  // ************************************************************
  typedef struct packed {
    logic overflow_flag;         // bit 7
    logic external_event_flag;   // bit 6
    logic rx_baud_select;        // bit 5
    logic tx_baud_select;        // bit 4
    logic external_input_enable; // bit 3
    logic run_control;           // bit 2
    logic counter_select;        // bit 1
    logic capture_select;        // bit 0
  } control_s;

  // ************************************************************
  // operating modes, highest priority first after off
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_BAUD = 3'b001,
    MODE_FREQGEN = 3'b010,
    MODE_CAPTURE = 3'b011,
    MODE_UPDOWN = 3'b100,
    MODE_RELOAD = 3'b101
  } mode_e;

  // serial clock ticks travel together
  typedef struct packed {
    logic rx_tick;
    logic tx_tick;
  } baud_ticks_s;

endpackage

// ==== logic/edge_sampler.sv ====
// samples a pin once per clock and flags a high-then-low pair
module edge_sampler (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin sample
  input wire logic pin_i,
  // results
  output logic level_o,
  output logic fall_o
);

  logic prev_r; // sample taken in the previous cycle

  // ************************************************************
  // sample register
  // ************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= 1'b0; // low after reset: no false fall at release
    end else begin
      prev_r <= pin_i;
    end
  end

  // fall seen in the cycle whose sample is low after a high one
  assign fall_o = prev_r & ~pin_i;
  assign level_o = prev_r;

endmodule

// ==== logic/enhanced_timer_counter_two.sv ====
// Chosen here: the address-and-strobe port.
`include "timer_two_params.svh"

// Summary of operation
// - timer counts prescaled clock, divide 1 to 16
// - counter counts pin high-then-low sample pairs
// - mode priority: off, baud, freqgen, capture, updown, reload
// - limits are 0000, ffff and reload register
// - overflow sets flag, never in baud mode
// - qualified trigger fall sets external event flag, except reload with down count set
// - external flag requests interrupt except with down count set
// - receive clock picks this or other overflow
// - transmit clock picks this or other overflow
// - trigger falls act only when enabled, not baud
// - counting only while run bit is one
// - counter select picks timer or pin counting
// - capture select chooses capture or reload on trigger
// - baud mode forces reload on overflow
// - count and reload bytes at cc..cd, ca..cb
// - control resets to zero, flags bits 7 and 6
// - capture copies count bytes into reload bytes
// - up-down direction follows trigger pin level
// - toggle count pin on overflow in freqgen, timer function only
module enhanced_timer_counter_two
  import timer_two_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o,
  // count pin, two-way
  input wire logic count_pin_i,
  output logic count_pin_o,
  output logic count_pin_oe_o,
  // trigger pin
  input wire logic trigger_pin_i,
  // serial port clocks
  input wire logic other_overflow_i,
  output logic rx_baud_tick_o,
  output logic tx_baud_tick_o,
  // interrupt request
  output logic timer_irq_o
);

  // ************************************************************
  // state
  // ************************************************************
  control_s ctrl_r;          // control register
  control_s ctrl_nxt;
  logic [1:0] mode_bits_r;   // down count and toggle enables
  logic [3:0] prescale_r;    // divide by this value plus one
  logic [3:0] presc_cnt_r;   // prescaler position
  logic [3:0] presc_cnt_nxt;
  logic [15:0] count_r;      // the count pair
  logic [15:0] count_nxt;
  logic [15:0] rcap_r;       // reload and capture pair
  logic [15:0] rcap_nxt;
  logic [7:0] rdata_r;       // read answer, one cycle late
  logic pin_out_r;           // toggled count pin level
  logic pin_oe_r;            // count pin driven
  baud_ticks_s ticks_r;      // serial clock pulses
  logic irq_r;               // interrupt request level
  logic ovf;                 // overflow in this cycle

  // ************************************************************
  // address decode
  // ************************************************************
  function automatic logic hit(input logic strobe,
                               input logic [7:0] addr,
                               input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction

  wire ctrl_we = hit(we_i, addr_i, `CTRL_ADDR);
  wire mode_we = hit(we_i, addr_i, `MODE_ADDR);
  wire psel_we = hit(we_i, addr_i, `PRESCALE_ADDR);
  wire rcap_lo_we = hit(we_i, addr_i, `RCAP_LO_ADDR);
  wire rcap_hi_we = hit(we_i, addr_i, `RCAP_HI_ADDR);
  wire cnt_lo_we = hit(we_i, addr_i, `CNT_LO_ADDR);
  wire cnt_hi_we = hit(we_i, addr_i, `CNT_HI_ADDR);

  // ************************************************************
  // mode selection
  // ************************************************************
  function automatic mode_e pick_mode(input control_s c,
                                      input logic down_en,
                                      input logic toggle_en);
    if (!c.run_control) begin
      pick_mode = MODE_OFF;
    end else if (c.rx_baud_select || c.tx_baud_select) begin
      pick_mode = MODE_BAUD;
    end else if (toggle_en) begin
      pick_mode = MODE_FREQGEN;
    end else if (c.capture_select) begin
      pick_mode = MODE_CAPTURE;
    end else if (down_en) begin
      pick_mode = MODE_UPDOWN;
    end else begin
      pick_mode = MODE_RELOAD;
    end
  endfunction

  wire down_en = mode_bits_r[`MODE_DOWN_BIT];
  wire toggle_en = mode_bits_r[`MODE_TOGGLE_BIT];
  wire baud_mode = ctrl_r.rx_baud_select | ctrl_r.tx_baud_select;
  wire mode_e cur_mode = pick_mode(ctrl_r, down_en, toggle_en);

  // ************************************************************
  // pin sampling
  // ************************************************************
  logic cnt_fall;  // high-then-low on the count pin
  logic trig_fall; // high-then-low on the trigger pin

  edge_sampler count_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(count_pin_i),
    .level_o(),
    .fall_o(cnt_fall)
  );

  edge_sampler trig_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(trigger_pin_i),
    .level_o(),
    .fall_o(trig_fall)
  );

  // ************************************************************
  // count enables
  // ************************************************************
  // prescaler wraps after prescale_r plus one clocks
  wire presc_wrap = (presc_cnt_r == prescale_r);
  // pin counting skips the prescaler entirely
  wire tick = ctrl_r.counter_select ? cnt_fall : presc_wrap;
  // trigger falls are ignored when disabled or feeding the uart
  wire trig_qual = trig_fall & ctrl_r.external_input_enable
                   & ~baud_mode;
  // in up-down mode the trigger pin steers, it does not reload
  wire trig_capture = trig_qual & ctrl_r.capture_select;
  wire trig_reload = trig_qual & ~ctrl_r.capture_select & ~down_en;
  wire count_up = (cur_mode == MODE_UPDOWN) ? trigger_pin_i
                                            : 1'b1;
  wire ovf_set = ovf & ~baud_mode;

  // prescaler only runs in timer function with run set
  always_comb begin
    presc_cnt_nxt = presc_cnt_r + 4'h1;
    if (!ctrl_r.run_control || ctrl_r.counter_select || presc_wrap) begin
      presc_cnt_nxt = 4'h0;
    end
  end

  // ************************************************************
  // counter next value
  // ************************************************************
  always_comb begin
    count_nxt = count_r;
    rcap_nxt = rcap_r;
    ovf = 1'b0;
    case (cur_mode)
      MODE_OFF: begin
        count_nxt = count_r; // held while stopped
      end
      MODE_UPDOWN: begin
        if (tick && count_up) begin
          if (count_r == `COUNT_MAX) begin
            ovf = 1'b1;
            count_nxt = rcap_r;
          end else begin
            count_nxt = count_r + 16'h0001;
          end
        end else if (tick) begin
          if (count_r == rcap_r) begin
            ovf = 1'b1;
            count_nxt = `COUNT_MAX;
          end else begin
            count_nxt = count_r - 16'h0001;
          end
        end
      end
      MODE_CAPTURE: begin
        // free running, wraps from ffff to 0000
        if (tick) begin
          ovf = (count_r == `COUNT_MAX);
          count_nxt = count_r + 16'h0001;
        end
      end
      MODE_RELOAD, MODE_BAUD, MODE_FREQGEN: begin
        // baud mode lands here whatever capture select says
        if (tick && count_r == `COUNT_MAX) begin
          ovf = 1'b1;
          count_nxt = rcap_r;
        end else if (tick) begin
          count_nxt = count_r + 16'h0001;
        end
      end
      default: begin
        count_nxt = count_r;
      end
    endcase
    // trigger events beat the count in the same cycle
    if (trig_capture) begin
      rcap_nxt = count_r;
    end else if (trig_reload) begin
      count_nxt = rcap_r;
    end
    // software byte writes take the last word
    if (rcap_lo_we) begin
      rcap_nxt[7:0] = wdata_i;
    end
    if (rcap_hi_we) begin
      rcap_nxt[15:8] = wdata_i;
    end
    if (cnt_lo_we) begin
      count_nxt[7:0] = wdata_i;
    end
    if (cnt_hi_we) begin
      count_nxt[15:8] = wdata_i;
    end
  end

  // ************************************************************
  // control next value
  // ************************************************************
  // hardware sets win over a software clear in the same cycle
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_we) begin
      ctrl_nxt = control_s'(wdata_i);
    end
    if (ovf_set) begin
      ctrl_nxt.overflow_flag = 1'b1;
    end
    if (trig_capture || trig_reload) begin
      ctrl_nxt.external_event_flag = 1'b1;
    end
  end

  // ************************************************************
  // read selection
  // ************************************************************
  wire [7:0] rd_sel =
    (addr_i == `CTRL_ADDR) ? ctrl_r :
    (addr_i == `MODE_ADDR) ? {6'h00, mode_bits_r} :
    (addr_i == `RCAP_LO_ADDR) ? rcap_r[7:0] :
    (addr_i == `RCAP_HI_ADDR) ? rcap_r[15:8] :
    (addr_i == `CNT_LO_ADDR) ? count_r[7:0] :
    (addr_i == `CNT_HI_ADDR) ? count_r[15:8] :
    (addr_i == `PRESCALE_ADDR) ? {4'h0, prescale_r} :
    8'h00; // unmapped reads as zero

  // ************************************************************
  // register update
  // ************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= control_s'(`CTRL_RESET);
      mode_bits_r <= `MODE_RESET;
      prescale_r <= `PRESCALE_RESET;
      presc_cnt_r <= 4'h0;
      count_r <= `WORD_RESET;
      rcap_r <= `WORD_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      mode_bits_r <= mode_we ? wdata_i[1:0] : mode_bits_r;
      prescale_r <= psel_we ? wdata_i[3:0] : prescale_r;
      presc_cnt_r <= presc_cnt_nxt;
      count_r <= count_nxt;
      rcap_r <= rcap_nxt;
    end
  end

  // ************************************************************
  // output registers
  // ************************************************************
  // pin is only driven as toggle output in timer function
  wire pin_drive = toggle_en & ~ctrl_r.counter_select;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
      ticks_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= re_i ? rd_sel : 8'h00;
      pin_oe_r <= pin_drive;
      pin_out_r <= (pin_drive && ovf) ? ~pin_out_r
                                      : pin_out_r;
      ticks_r.rx_tick <= ctrl_r.rx_baud_select ? ovf
                                               : other_overflow_i;
      ticks_r.tx_tick <= ctrl_r.tx_baud_select ? ovf
                                               : other_overflow_i;
      // down count enable keeps the event flag off the request line, in any mode
      irq_r <= ctrl_r.overflow_flag |
               (ctrl_r.external_event_flag & ~down_en);
    end
  end

  assign rdata_o = rdata_r;
  assign count_pin_o = pin_out_r;
  assign count_pin_oe_o = pin_oe_r;
  assign rx_baud_tick_o = ticks_r.rx_tick;
  assign tx_baud_tick_o = ticks_r.tx_tick;
  assign timer_irq_o = irq_r;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  presc_step_a: assert property (
    cur_mode == MODE_RELOAD && !ctrl_r.counter_select && presc_wrap
    && !we_i && !trig_qual && count_r != `COUNT_MAX
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("timer step missing on prescaler wrap");

  pin_count_a: assert property (
    cur_mode == MODE_RELOAD && ctrl_r.counter_select && cnt_fall
    && !we_i && !trig_qual && count_r != `COUNT_MAX
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("pin fall not counted");

  run_hold_a: assert property (
    !ctrl_r.run_control && !we_i && !trig_qual |=> $stable(count_r))
    else $error("count moved while stopped");

  ovf_flag_a: assert property (
    ovf && !baud_mode |=> ctrl_r.overflow_flag)
    else $error("overflow flag not set");

  baud_noflag_a: assert property (
    baud_mode && !ctrl_r.overflow_flag && !ctrl_we
    |=> !ctrl_r.overflow_flag)
    else $error("overflow flag set in baud mode");

  reload_ovf_a: assert property (
    cur_mode == MODE_RELOAD && ovf && !we_i && !trig_qual
    |=> count_r == $past(rcap_r) && ctrl_r.overflow_flag)
    else $error("reload missing on overflow");

  capture_copy_a: assert property (
    trig_capture && !rcap_lo_we && !rcap_hi_we
    |=> rcap_r == $past(count_r) && ctrl_r.external_event_flag)
    else $error("capture did not copy count");

  trig_ignore_a: assert property (
    !ctrl_r.external_input_enable && !ctrl_r.external_event_flag
    && !ctrl_we |=> !ctrl_r.external_event_flag)
    else $error("trigger acted while disabled");

  pin_toggle_a: assert property (
    pin_drive && ovf |=> count_pin_o != $past(count_pin_o))
    else $error("count pin did not toggle");

  read_count_a: assert property (
    re_i && addr_i == `CNT_LO_ADDR |=> rdata_o == $past(count_r[7:0])
    ##1 rdata_o == 8'h00 || $past(re_i))
    else $error("count low byte read wrong");

  updown_irq_a: assert property (
    down_en && !ctrl_r.overflow_flag && !ovf_set && !ctrl_we
    ##1 down_en && !ctrl_r.overflow_flag |=> !timer_irq_o)
    else $error("event flag raised irq in up-down mode");

endmodule

// ==== dv/pin_partner.sv ====
// ************************************************************
// far side of the timer: count source, trigger, other timer
// ************************************************************
module pin_partner (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels asked for by the bench
  input wire logic cnt_lvl_i,
  input wire logic trig_lvl_i,
  input wire logic ovf_req_i,
  // design side of the two-way count pin
  input wire logic dut_pin_i,
  input wire logic dut_oe_i,
  // pin levels seen by the design
  output logic count_pin_o,
  output logic trigger_pin_o,
  output logic other_overflow_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cnt_lvl_r; // source level, held a whole cycle at least

  // levels change only on an edge, never mid-cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_lvl_r <= 1'b0;
      trigger_pin_o <= 1'b1;
      other_overflow_o <= 1'b0;
    end else begin
      cnt_lvl_r <= cnt_lvl_i;
      trigger_pin_o <= trig_lvl_i;
      other_overflow_o <= ovf_req_i; // one pulse per request
    end
  end

  // whoever enables drives the wire; no pull, so source wins else
  assign count_pin_o = dut_oe_i ? dut_pin_i : cnt_lvl_r;
endmodule

// ==== dv/tb_top.sv ====
`include "timer_two_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import timer_two_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [7:0] rdata;
  logic cnt_lvl = 1'b0;
  logic trig_lvl = 1'b1; // trigger idles high
  logic ovf_req = 1'b0;
  logic pin_wire, pin_out, pin_oe, trig_wire, other_ovf;
  logic rx_tick, tx_tick, irq;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int t0;

  always #5 clk_i = ~clk_i;

  enhanced_timer_counter_two DUT (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
    .rdata_o(rdata), .count_pin_i(pin_wire), .count_pin_o(pin_out),
    .count_pin_oe_o(pin_oe), .trigger_pin_i(trig_wire),
    .other_overflow_i(other_ovf), .rx_baud_tick_o(rx_tick),
    .tx_baud_tick_o(tx_tick), .timer_irq_o(irq));

  pin_partner partner (.clk_i(clk_i), .rst_i(rst_i),
    .cnt_lvl_i(cnt_lvl), .trig_lvl_i(trig_lvl), .ovf_req_i(ovf_req),
    .dut_pin_i(pin_out), .dut_oe_i(pin_oe), .count_pin_o(pin_wire),
    .trigger_pin_o(trig_wire), .other_overflow_o(other_ovf));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    @(negedge clk_i);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  // high-then-low on the trigger, each level held three cycles
  task automatic trig_fall();
    @(posedge clk_i);
    trig_lvl <= 1'b0;
    repeat (3) @(posedge clk_i);
    trig_lvl <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  // bounded wait for a design output, sampled mid-cycle
  task automatic wait_hi(input int which, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++) begin
      @(negedge clk_i);
      seen = (which == 0) ? irq : (which == 1) ? tx_tick : rx_tick;
    end
  endtask

  task automatic load(input logic [15:0] rl, input logic [15:0] c);
    wr(`RCAP_LO_ADDR, rl[7:0]);
    wr(`RCAP_HI_ADDR, rl[15:8]);
    wr(`CNT_LO_ADDR, c[7:0]);
    wr(`CNT_HI_ADDR, c[15:8]);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rd(`CTRL_ADDR, 8'h00);
    rd(`CNT_LO_ADDR, 8'h00);
    rd(`RCAP_HI_ADDR, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
  endtask

  // overflow in plain reload mode, divide by four
  task automatic t_overflow();
    logic s;
    wr(`PRESCALE_ADDR, 8'h03);
    load(16'h1234, 16'hfffe);
    wr(`CTRL_ADDR, 8'h04);
    wait_hi(0, s);
    chk({15'h0, s}, 16'h0001);
    // stop, writing the flag as one so that it stays set
    wr(`CTRL_ADDR, 8'h80);
    rd(`CNT_LO_ADDR, 8'h34);
    rd(`CNT_HI_ADDR, 8'h12);
    rd(`CTRL_ADDR, 8'h80);
    chk({15'h0, irq}, 16'h0001);
  endtask

  // five falls on the count pin with the timer clock ignored
  task automatic t_counter();
    load(16'h0000, 16'h0000);
    wr(`CTRL_ADDR, 8'h06);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      cnt_lvl <= 1'b1;
      repeat (2) @(posedge clk_i);
      cnt_lvl <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
    wr(`CTRL_ADDR, 8'h00);
    rd(`CNT_LO_ADDR, 8'h05);
  endtask

  task automatic t_capture();
    load(16'h0034, 16'habcd);
    wr(`CTRL_ADDR, 8'h01);
    trig_fall();
    rd(`RCAP_LO_ADDR, 8'h34);
    wr(`CTRL_ADDR, 8'h09);
    trig_fall();
    rd(`RCAP_LO_ADDR, 8'hcd);
    rd(`RCAP_HI_ADDR, 8'hab);
    rd(`CTRL_ADDR, 8'h49);
    chk({15'h0, irq}, 16'h0001);
    wr(`CTRL_ADDR, 8'h00);
  endtask

  task automatic t_trig_reload();
    load(16'h5555, 16'h1111);
    wr(`CTRL_ADDR, 8'h08);
    trig_fall();
    rd(`CNT_LO_ADDR, 8'h55);
    rd(`CNT_HI_ADDR, 8'h55);
    rd(`CTRL_ADDR, 8'h48);
    wr(`CTRL_ADDR, 8'h00);
  endtask

  // trigger held low while counting: count must fall
  task automatic t_updown();
    wr(`MODE_ADDR, 8'h01);
    load(16'h0000, 16'h0010);
    trig_lvl <= 1'b0;
    wr(`CTRL_ADDR, 8'h0c);
    repeat (12) @(posedge clk_i);
    wr(`CTRL_ADDR, 8'h00);
    // three steps down at divide by four: 0010 to 000d
    rd(`CNT_LO_ADDR, 8'h0d);
    rd(`CNT_HI_ADDR, 8'h00);
    rd(`CTRL_ADDR, 8'h00);
    @(posedge clk_i);
    trig_lvl <= 1'b1;
    // capture with down count set: flag rises, request stays low
    wr(`CTRL_ADDR, 8'h09);
    trig_fall();
    rd(`CTRL_ADDR, 8'h49);
    chk({15'h0, irq}, 16'h0000);
    wr(`CTRL_ADDR, 8'h00);
    wr(`MODE_ADDR, 8'h00);
  endtask

  // pin toggles on every overflow, one overflow each two cycles
  task automatic t_freqgen();
    logic prev;
    int flips;
    flips = 0;
    wr(`MODE_ADDR, 8'h02);
    wr(`PRESCALE_ADDR, 8'h00);
    load(16'hfffe, 16'hfffe);
    wr(`CTRL_ADDR, 8'h04);
    repeat (4) @(negedge clk_i);
    prev = pin_wire;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if (pin_wire !== prev) flips++;
      prev = pin_wire;
    end
    chk(flips[15:0], 16'd10);
    chk({15'h0, pin_oe}, 16'h0001);
    chk({15'h0, irq}, 16'h0001);
    wr(`CTRL_ADDR, 8'h00);
    wr(`MODE_ADDR, 8'h00);
  endtask

  // baud mode ignores capture select and never sets the flag
  task automatic t_baud();
    logic s;
    wr(`PRESCALE_ADDR, 8'h03);
    load(16'hfffe, 16'hfffe);
    wr(`CTRL_ADDR, 8'h35);
    wait_hi(1, s);
    chk({15'h0, rx_tick}, 16'h0001);
    t0 = cycles;
    @(negedge clk_i);
    wait_hi(1, s);
    chk(16'(cycles - t0), 16'd8);
    // still running: two overflows passed, flag must be clear
    rd(`CTRL_ADDR, 8'h35);
    wr(`CTRL_ADDR, 8'h10);
    @(posedge clk_i);
    ovf_req <= 1'b1;
    @(posedge clk_i);
    ovf_req <= 1'b0;
    wait_hi(2, s);
    chk({15'h0, s}, 16'h0001);
    wr(`CTRL_ADDR, 8'h00);
  endtask

  // ************************************************************
  // run control and hang guard
  // ************************************************************
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_overflow();
    t_counter();
    t_capture();
    t_trig_reload();
    t_updown();
    t_freqgen();
    t_baud();
    conclude();
  end
endmodule
